// *** hw/mode_bus_top.sv ***
`timescale 1ns/100ps
module mode_bus_top (
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   srst_in,
    // mode-select pins
    input  wire logic                   mode_select_high_in,
    input  wire logic                   mode_select_low_in,
    // cpu side request, taken at cycle start
    input  wire mode_bus_pkg::bus_req_s req_in,
    output logic                        req_taken_out,
    output logic                        rdata_valid_out,
    output logic [7:0]                  rdata_out,
    output logic                        ext_access_out,
    // mode status
    output mode_bus_pkg::op_mode_e      mode_out,
    output logic                        boot_rom_sel_out,
    output logic                        privileged_out,
    output logic                        prog_mem_on_out,
    output logic                        gpio_release_out,
    // expansion bus pins
    output logic [7:0]                  addr_high_out,
    output logic                        addr_high_oe_out,
    input  wire logic [7:0]             ad_in,
    output logic [7:0]                  ad_out,
    output logic                        ad_oe_out,
    output logic                        addr_latch_enable_out,
    output logic                        rw_out,
    output logic                        phase_clk_out,
    output logic                        strobe_oe_out
);
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic [7:0] ad_meta;
    logic [7:0] ad_sync;
    mode_bus_pkg::op_mode_e  mode;
    mode_bus_pkg::mode_ctl_s ctl;
    logic ph;
    logic cyc_start;
    logic rise;

    // pins pass two flops before use
    always_ff @(posedge core_clk_in) begin
        sel_meta <= {mode_select_high_in, mode_select_low_in};
        sel_sync <= sel_meta;
        ad_meta  <= ad_in;
        ad_sync  <= ad_meta;
    end

    mode_latch u_mode (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .sel_sync_in (sel_sync),
        .mode_out    (mode),
        .ctl_out     (ctl)
    );

    phase_gen u_phase (
        .core_clk_in     (core_clk_in),
        .srst_in         (srst_in),
        .phase_high_out  (ph),
        .cycle_start_out (cyc_start),
        .rise_out        (rise)
    );

    function automatic logic in_boot_rom(input logic [15:0] a);
        return (a >= mode_bus_pkg::BOOT_ROM_BASE) &&
               (a <= mode_bus_pkg::BOOT_ROM_TOP);
    endfunction

    mode_bus_pkg::bus_req_s cur;
    mode_bus_pkg::bus_req_s next_cur;
    logic       taken, next_taken;
    logic       ale, next_ale;
    logic       rw, next_rw;
    logic       oe, next_oe;
    logic [7:0] ad, next_ad;
    logic [7:0] ah, next_ah;
    logic       ah_oe, next_ah_oe;
    logic       pclk, next_pclk;
    logic       rv, next_rv;
    logic [7:0] rd, next_rd;
    logic       ext, next_ext;
    logic       pend, next_pend;
    logic       pend_ext, next_pend_ext;
    logic       ext_cycle;

    // R3 R6 internal and boot ROM accesses are not flagged external; in expanded mode internal addresses still go out on the pins
    assign ext_cycle = ctl.expanded && cur.valid && !cur.internal &&
                       !(ctl.boot_rom_on && in_boot_rom(cur.addr));

    always_comb begin
        next_cur   = cur;
        next_taken = 1'b0;
        next_ale   = ale;
        next_rw    = rw;
        next_oe    = oe;
        next_ad    = ad;
        next_ah    = ah;
        next_ah_oe = ctl.expanded;
        // pin copy of the phase flop, same cycle as the phase itself
        next_pclk  = ph ^ (cyc_start || rise);
        next_rv    = 1'b0;
        next_rd    = rd;
        next_ext   = 1'b0;
        next_pend     = pend;
        next_pend_ext = pend_ext;
        if (cyc_start) begin
            next_cur   = req_in;
            next_taken = req_in.valid;
            if (ctl.expanded) begin
                // R7 R8 R9 R10 address phase, strobe high
                next_ah  = req_in.addr[15:8];
                next_ad  = req_in.addr[7:0];
                next_oe  = 1'b1;
                next_ale = 1'b1;
                // R12 idle cycles read, writes stay low
                next_rw  = !(req_in.valid && req_in.write);
            end
        end else if (rise) begin
            next_ale = 1'b0;
            if (ctl.expanded) begin
                // R8 data phase: drive for write, release for read
                next_ad = cur.wdata;
                next_oe = cur.valid && cur.write;
            end
        end
        // R11 read data: pins lag two sync flops, so the last
        // high-phase byte is taken at the following rise
        if (cyc_start) begin
            next_pend     = cur.valid && !cur.write && ctl.expanded;
            next_pend_ext = ext_cycle;
        end else if (rise && pend) begin
            next_rv   = 1'b1;
            next_rd   = ad_sync;
            next_ext  = pend_ext;
            next_pend = 1'b0;
        end
        // R4 single-chip releases ports
        if (!ctl.expanded) begin
            next_ale = 1'b0;
            next_oe  = 1'b0;
            next_rw  = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cur   <= '0;
            taken <= 1'b0;
            ale   <= 1'b0;
            rw    <= 1'b1;
            oe    <= 1'b0;
            ad    <= 8'h00;
            ah    <= 8'h00;
            ah_oe <= 1'b0;
            pclk  <= 1'b0;
            rv    <= 1'b0;
            rd    <= 8'h00;
            ext   <= 1'b0;
            pend     <= 1'b0;
            pend_ext <= 1'b0;
        end else begin
            cur   <= next_cur;
            taken <= next_taken;
            ale   <= next_ale;
            rw    <= next_rw;
            oe    <= next_oe;
            ad    <= next_ad;
            ah    <= next_ah;
            ah_oe <= next_ah_oe;
            pclk  <= next_pclk;
            rv    <= next_rv;
            rd    <= next_rd;
            ext   <= next_ext;
            pend     <= next_pend;
            pend_ext <= next_pend_ext;
        end
    end

    // mode status registered so outputs come from flops
    mode_bus_pkg::op_mode_e mode_q;
    logic boot_q, priv_q, prog_q, rel_q;
    always_ff @(posedge core_clk_in) begin
        mode_q <= mode;
        // R15 R16 bootstrap ROM mapped in boot mode
        boot_q <= ctl.boot_rom_on;
        // R14 test mode grants privileged writes
        priv_q <= ctl.privileged;
        prog_q <= ctl.prog_mem_on;
        rel_q  <= ctl.single_chip;
    end

    assign req_taken_out         = taken;
    assign rdata_valid_out       = rv;
    assign rdata_out             = rd;
    assign ext_access_out        = ext;
    assign mode_out              = mode_q;
    assign boot_rom_sel_out      = boot_q;
    assign privileged_out        = priv_q;
    assign prog_mem_on_out       = prog_q;
    assign gpio_release_out      = rel_q;
    assign addr_high_out         = ah;
    assign addr_high_oe_out      = ah_oe;
    assign ad_out                = ad;
    assign ad_oe_out             = oe;
    assign addr_latch_enable_out = ale;
    assign rw_out                = rw;
    assign phase_clk_out         = pclk;
    assign strobe_oe_out         = 1'b0;
endmodule

// *** hw/mode_bus_pkg.sv ***
// Overview of operation
// R1 - mode from select pins during reset
// R2 - two normal modes, each with special
// R3 - single-chip issues no external accesses
// R4 - single-chip frees ports and strobes
// R5 - single-chip enables program memory, top vectors
// R6 - expanded covers full 64K, internal served inside
// R7 - high byte port, low port shared
// R8 - address first half, data second half
// R9 - strobe high while address valid
// R10 - address and strobe on every cycle
// R11 - external read data only clock high
// R12 - write low, stays low back-to-back
// R13 - glue forms write enable from clock
// R14 - test mode expanded plus privileged access
// R15 - bootstrap like single-chip, loader start
// R16 - bootstrap ROM at top of 48K
// R17 - mode code configurable, latched at release
package mode_bus_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXPANDED,
        MODE_BOOT,
        MODE_TEST
    } op_mode_e;

    // mode-select code {high,low} for each mode
    localparam logic [1:0] SEL_SINGLE   = 2'h1;
    localparam logic [1:0] SEL_EXPANDED = 2'h3;
    localparam logic [1:0] SEL_BOOT     = 2'h0;
    localparam logic [1:0] SEL_TEST     = 2'h2;

    localparam logic [15:0] VECTOR_BASE   = 16'hFFC0;
    localparam logic [15:0] BOOT_ROM_BASE = 16'hBF00;
    localparam logic [15:0] BOOT_ROM_TOP  = 16'hBFFF;
    localparam logic [15:0] BOOT_VEC_BASE = 16'hBFC0;

    // bus phase clock divide: half period in core cycles
    localparam int unsigned PHASE_HALF = 2;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        internal;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bus_req_s;

    typedef struct packed {
        logic        single_chip;
        logic        expanded;
        logic        boot_rom_on;
        logic        privileged;
        logic        prog_mem_on;
    } mode_ctl_s;

endpackage

// *** hw/mode_latch.sv ***
`timescale 1ns/100ps
module mode_latch (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  srst_in,
    // synchronised select levels
    input  wire logic [1:0]            sel_sync_in,
    // decoded mode
    output mode_bus_pkg::op_mode_e     mode_out,
    output mode_bus_pkg::mode_ctl_s    ctl_out
);
    mode_bus_pkg::op_mode_e mode;
    mode_bus_pkg::op_mode_e next_mode;
    logic                   in_reset;

    function automatic mode_bus_pkg::op_mode_e decode(input logic [1:0] s);
        mode_bus_pkg::op_mode_e m;
        m = mode_bus_pkg::MODE_SINGLE;
        if (s == mode_bus_pkg::SEL_EXPANDED) m = mode_bus_pkg::MODE_EXPANDED;
        if (s == mode_bus_pkg::SEL_BOOT)     m = mode_bus_pkg::MODE_BOOT;
        if (s == mode_bus_pkg::SEL_TEST)     m = mode_bus_pkg::MODE_TEST;
        return m;
    endfunction

    // R1 R17 sample during reset
    always_comb begin
        next_mode = mode;
        if (srst_in || in_reset) begin
            next_mode = decode(sel_sync_in);
        end
    end

    // mode frozen from the first edge after release
    always_ff @(posedge core_clk_in) begin
        in_reset <= srst_in;
        mode     <= next_mode;
    end

    // R2 R14 R15 pairing of normal and special modes
    always_comb begin
        ctl_out.single_chip = (mode == mode_bus_pkg::MODE_SINGLE) ||
                              (mode == mode_bus_pkg::MODE_BOOT);
        ctl_out.expanded    = !ctl_out.single_chip;
        ctl_out.boot_rom_on = (mode == mode_bus_pkg::MODE_BOOT);
        ctl_out.privileged  = (mode == mode_bus_pkg::MODE_TEST);
        // R5 program memory on out of reset
        ctl_out.prog_mem_on = (mode == mode_bus_pkg::MODE_SINGLE);
    end

    assign mode_out = mode;
endmodule

// *** hw/phase_gen.sv ***
`timescale 1ns/100ps
module phase_gen #(
    parameter int unsigned HALF = mode_bus_pkg::PHASE_HALF
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    // phase outputs
    output logic      phase_high_out,
    output logic      cycle_start_out,
    output logic      rise_out
);
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

    initial begin
        if (HALF < 1) $error("HALF must be at least 1");
    end

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          ph;
    logic          next_ph;
    logic          wrap;

    assign wrap = (cnt == CW'(HALF - 1));

    always_comb begin
        next_cnt = wrap ? '0 : cnt + 1'b1;
        next_ph  = wrap ? !ph : ph;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cnt <= '0;
            ph  <= 1'b0;
        end else begin
            cnt <= next_cnt;
            ph  <= next_ph;
        end
    end

    assign phase_high_out  = ph;
    assign cycle_start_out = wrap && ph;
    assign rise_out        = wrap && !ph;
endmodule

// *** bench/mode_bus_assertions.sv ***
`timescale 1ns/100ps
module mode_bus_assertions (
    input wire logic                   core_clk_in,
    input wire logic                   srst_in,
    input wire mode_bus_pkg::bus_req_s req_in,
    input wire mode_bus_pkg::op_mode_e mode_out,
    input wire logic                   rdata_valid_out,
    input wire logic                   req_taken_out,
    input wire logic                   ext_access_out,
    input wire logic                   boot_rom_sel_out,
    input wire logic                   privileged_out,
    input wire logic                   gpio_release_out,
    input wire logic                   addr_high_oe_out,
    input wire logic [7:0]             addr_high_out,
    input wire logic [7:0]             ad_out,
    input wire logic                   ad_oe_out,
    input wire logic                   addr_latch_enable_out,
    input wire logic                   rw_out,
    input wire logic                   phase_clk_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic [1:0] up;
    // mode may still settle on the first edge after release
    always_ff @(posedge core_clk_in)
        up <= srst_in ? 2'h0 : (up[1] ? up : up + 2'h1);

    a_mode_held: assert property (up[1] |-> $stable(mode_out))
        else $error("mode changed after reset");
    a_status_map: assert property (up[1] |->
        boot_rom_sel_out == (mode_out == mode_bus_pkg::MODE_BOOT) &&
        privileged_out == (mode_out == mode_bus_pkg::MODE_TEST) &&
        gpio_release_out == (mode_out inside
            {mode_bus_pkg::MODE_SINGLE, mode_bus_pkg::MODE_BOOT}))
        else $error("status flags disagree with mode");
    a_single_quiet: assert property (gpio_release_out |->
        !ad_oe_out && !addr_high_oe_out && !rdata_valid_out &&
        !ext_access_out) else $error("bus active in single-chip");
    a_addr_phase: assert property ($rose(addr_latch_enable_out) |->
        (addr_latch_enable_out && !phase_clk_out && ad_oe_out)[*2]
        ##1 (!addr_latch_enable_out && phase_clk_out))
        else $error("address phase shape wrong");
    a_addr_pins: assert property ($rose(addr_latch_enable_out) |->
        ad_out == $past(req_in.addr[7:0]) &&
        addr_high_out == $past(req_in.addr[15:8]) &&
        rw_out == !($past(req_in.valid) && $past(req_in.write)))
        else $error("address pins wrong");
    a_turn_round: assert property ($rose(phase_clk_out) &&
        $past(addr_latch_enable_out) |-> ad_oe_out == !rw_out)
        else $error("data phase direction wrong");
    a_rw_b2b: assert property (($rose(addr_latch_enable_out) &&
        !rw_out ##4 $rose(addr_latch_enable_out) && !rw_out) |->
        !$past(rw_out) && !$past(rw_out, 2) && !$past(rw_out, 3))
        else $error("rw rose between writes");
    a_read_done: assert property ($rose(phase_clk_out) &&
        $past(addr_latch_enable_out) && $past(req_taken_out, 2) &&
        rw_out && !gpio_release_out
        |-> ##[1:6] rdata_valid_out) else $error("read data missing");
    a_phase_clock: assert property ($rose(phase_clk_out) |->
        phase_clk_out[*2] ##1 (!phase_clk_out)[*2] ##1 phase_clk_out)
        else $error("phase clock period wrong");
endmodule

// *** bench/ext_bus_memory.sv ***
`timescale 1ns/100ps
module ext_bus_memory (
    // bus pins from the device
    input  wire logic       core_clk_in,
    input  wire logic [7:0] addr_high_in,
    input  wire logic [7:0] ad_in,
    input  wire logic       ale_in,
    input  wire logic       rw_in,
    input  wire logic       pclk_in,
    // level this side puts on the shared pins
    output logic [7:0]      ad_drv_out
);
    logic [7:0] mem [65536];
    logic [7:0] lo;
    logic [7:0] last = 8'h00;
    logic       we_n;
    // address latch follows pins while strobe high
    // sampled per clock so the strobe fall and the data switch never race
    always @(posedge core_clk_in) if (ale_in) lo <= ad_in;
    assign we_n = ~(pclk_in & ~rw_in);
    always @(posedge core_clk_in) if (!we_n) mem[{addr_high_in, lo}] <= ad_in;
    // drive only while clock high on reads
    // released pins toggle so a stale byte is never mistaken for data
    assign ad_drv_out = (pclk_in === 1'b1 && rw_in === 1'b1) ?
        mem[{addr_high_in, lo}] : ~last;
    always @(posedge core_clk_in) last <= ad_in;
endmodule

// *** bench/mode_bus_top_tb.sv ***
`timescale 1ns/100ps
module mode_bus_top_tb;
    logic                   core_clk_in = 1'b0;
    logic                   srst_in = 1'b1;
    logic                   mode_select_high_in = 1'b0;
    logic                   mode_select_low_in = 1'b0;
    mode_bus_pkg::bus_req_s req_in = '0;
    mode_bus_pkg::op_mode_e mode_out;
    logic                   req_taken_out, rdata_valid_out, ext_access_out;
    logic                   boot_rom_sel_out, privileged_out, prog_mem_on_out;
    logic                   gpio_release_out, addr_high_oe_out, ad_oe_out;
    logic                   addr_latch_enable_out, rw_out, phase_clk_out;
    logic                   strobe_oe_out, exp_bus;
    logic [7:0]             rdata_out, addr_high_out, ad_out, ad_drv;
    wire logic [7:0]        ad_in;
    logic [8:0]             q [$];
    logic [8:0]             exp_rd;
    logic [7:0]             ref_mem [logic [15:0]];
    logic [15:0]            wa [4];
    logic [1:0]             sel [4] = '{mode_bus_pkg::SEL_SINGLE,
        mode_bus_pkg::SEL_EXPANDED, mode_bus_pkg::SEL_BOOT,
        mode_bus_pkg::SEL_TEST};
    int                     failures = 0, n_tests = 0, n;

    mode_bus_top dut (.*);
    ext_bus_memory mem (.core_clk_in, .addr_high_in(addr_high_out), .ad_in,
        .ale_in(addr_latch_enable_out), .rw_in(rw_out),
        .pclk_in(phase_clk_out), .ad_drv_out(ad_drv));
    assign ad_in = (ad_oe_out === 1'b1) ? ad_out : ad_drv;

    always #4 core_clk_in = ~core_clk_in;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // request held until taken is seen, then the next may follow at once
    task xfer(input logic w, input logic it, input logic [15:0] ad,
              input logic [7:0] d);
        #1 req_in = '{1'b1, w, it, ad, d};
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (req_taken_out !== 1'b1 && n < 12);
        if (exp_bus) check(req_taken_out, 1'b1);
        if (w && !it) ref_mem[ad] = d;
        else if (!w && exp_bus) q.push_back({!it, ref_mem[ad]});
    endtask

    always @(posedge core_clk_in) begin
        if (rdata_valid_out === 1'b1) begin
            if (q.size() == 0) check(1'b1, 1'b0);
            else begin
                exp_rd = q.pop_front();
                check(rdata_out, exp_rd[7:0]);
                check(ext_access_out, exp_rd[8]);
            end
        end
    end

    initial begin
        #100000;
        failures++;
        give_verdict;
    end

    initial begin
        void'($urandom(5));
        for (int m = 0; m < 4; m++) begin
            #1 srst_in = 1'b1;
            {mode_select_high_in, mode_select_low_in} = sel[m];
            exp_bus = m[0];
            repeat (20) @(posedge core_clk_in);
            #1 srst_in = 1'b0;
            repeat (4) @(posedge core_clk_in);
            check(16'(mode_out), 16'(m));
            check(prog_mem_on_out, m == 0);
            check(addr_high_oe_out, m[0]);
            check(strobe_oe_out, 1'b0);
            #1 {mode_select_high_in, mode_select_low_in} = ~sel[m];
            @(posedge core_clk_in);
            for (int i = 0; i < 4; i++) begin
                wa[i] = 16'($urandom);
                xfer(1'b1, i == 3, wa[i], 8'($urandom));
            end
            for (int i = 0; i < 3; i++) xfer(1'b0, i == 2, wa[i], 8'h00);
            #1 req_in.valid = 1'b0;
            repeat (12) @(posedge core_clk_in);
            check(16'(mode_out), 16'(m));
            check(16'(q.size()), 16'h0000);
        end
        give_verdict;
    end
endmodule

bind mode_bus_top mode_bus_assertions chk (.*);
